/* File: hw/dir_defines.svh */
// address map, field positions, fixed values and reset values of the identification bank
`ifndef DIR_DEFINES_SVH
`define DIR_DEFINES_SVH

// full addresses in the extended function register space
`define DIR_PROGV_ADDR      16'hf078
`define DIR_MEMDESC_ADDR    16'hf07a
`define DIR_PART_ADDR       16'hf07c
`define DIR_MAKER_ADDR      16'hf07e

// short (word) addresses of the same registers
`define DIR_PROGV_SHORT     8'h3c
`define DIR_MEMDESC_SHORT   8'h3d
`define DIR_PART_SHORT      8'h3e
`define DIR_MAKER_SHORT     8'h3f

// memory descriptor field positions
`define DIR_MEMTECH_MSB     15
`define DIR_MEMTECH_LSB     12
`define DIR_MEMCAP_MSB      11
`define DIR_MEMCAP_LSB      0
`define DIR_BUSY_HI_BIT     15
`define DIR_BUSY_LO_BIT     14

// memory technology codes, 4h..fh reserved
`define DIR_MEMTECH_NONE    4'h0
`define DIR_MEMTECH_MROM    4'h1
`define DIR_MEMTECH_SFLASH  4'h2
`define DIR_MEMTECH_HPFLASH 4'h3

// capacity in units of 4 kilobytes: 0d0h gives 832 kilobytes
`define DIR_MEMCAP_UNIT_KB  4
`define DIR_MEMCAP_VALUE    12'h0d0

// programming supply: volts = 20 * level / 256, 40h gives 5 V
`define DIR_SUPPLY_DIVISOR  256
`define DIR_SUPPLY_VALUE    8'h40
`define DIR_HIGHV_VALUE     8'h00

// fixed low bits of the maker word
`define DIR_MAKER_TAIL      5'h03

// reset and not-yet-initialised values
`define DIR_MEMDESC_RESET   16'h30d0
`define DIR_MEMDESC_BUSY    16'hf0d0
`define DIR_PROGV_RESET     16'h0040

`endif

/* File: hw/dir_pkg.sv */
// types shared by the identification bank modules
`default_nettype none
package dir_pkg;

    // register index, in address order
    typedef enum logic [1:0] {
        DIR_IDX_PROGV,
        DIR_IDX_MEMDESC,
        DIR_IDX_PART,
        DIR_IDX_MAKER
    } dir_idx_t;

    // outcome of an address decode
    typedef struct packed {
        logic     hit;
        dir_idx_t idx;
    } dir_hit_t;

    // one register access from the cpu side
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        short_sel;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dir_req_t;

    typedef struct packed {
        logic [10:0] maker_code;
        logic [4:0]  tail;
    } dir_maker_t;

    typedef struct packed {
        logic [11:0] part_id;
        logic [3:0]  silicon_revision;
    } dir_part_t;

    typedef struct packed {
        logic [3:0]  memory_technology;
        logic [11:0] memory_capacity;
    } dir_memdesc_t;

    typedef struct packed {
        logic [7:0] program_high_voltage_level;
        logic [7:0] program_supply_level;
    } dir_progv_t;

    // init tracking states
    typedef enum logic [1:0] {
        DIR_ST_RESET,
        DIR_ST_WAIT_FLASH,
        DIR_ST_READY
    } dir_state_t;

endpackage : dir_pkg
`default_nettype wire

/* File: hw/dir_rom.sv */
// identification word store with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "dir_defines.svh"

module dir_rom (
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic             load_in,
    input  wire logic             zero_in,
    input  wire dir_pkg::dir_idx_t idx_in,
    input  wire logic             ready_in,
    input  wire logic [10:0]      maker_code_in,
    input  wire logic [11:0]      part_id_in,
    input  wire logic [3:0]       silicon_revision_in,
    output logic [15:0]           rd_data_out
);

    logic [15:0] word_d;
    logic [15:0] rd_data_q;

    // word lookup; the memory and supply words change with init state only
    always_comb begin
        dir_pkg::dir_maker_t   maker;
        dir_pkg::dir_part_t    part;
        dir_pkg::dir_memdesc_t mem;
        dir_pkg::dir_progv_t   progv;
        maker = '{maker_code: maker_code_in, tail: `DIR_MAKER_TAIL};
        part = '{part_id: part_id_in, silicon_revision: silicon_revision_in};
        mem = '{memory_technology: `DIR_MEMTECH_HPFLASH,
                memory_capacity: `DIR_MEMCAP_VALUE};
        progv = '{program_high_voltage_level: `DIR_HIGHV_VALUE,
                  program_supply_level: `DIR_SUPPLY_VALUE};
        case (idx_in)
            dir_pkg::DIR_IDX_MAKER: begin
                word_d = maker;
            end
            dir_pkg::DIR_IDX_PART: begin
                word_d = part;
            end
            dir_pkg::DIR_IDX_MEMDESC: begin
                // busy pattern until ready_in is set: after flash init, or at once on internal boot
                word_d = ready_in ? 16'(mem) : `DIR_MEMDESC_BUSY;
            end
            dir_pkg::DIR_IDX_PROGV: begin
                word_d = ready_in ? 16'(progv) : `DIR_PROGV_RESET;
            end
            default: begin
                word_d = 16'h0000;
            end
        endcase
    end

    // read register: holds the last word between reads
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rd_data_q <= 16'h0000;
        end else if (zero_in) begin
            rd_data_q <= 16'h0000;
        end else if (load_in) begin
            rd_data_q <= word_d;
        end
    end

    assign rd_data_out = rd_data_q;

endmodule : dir_rom
`default_nettype wire

/* File: hw/dir_top.sv */
// read-only identification register bank in the extended function register space
//
// Behaviour
// - four 16-bit registers, full and short addresses
// - all read-only; writes change nothing
// - maker register returns normalised maker identifier
// - part id upper field, revision lowest nibble
// - capacity field reports 832 kilobytes (0d0h)
// - technology codes 0-3; this part reports 3
// - supply field reports 40h for five volts
// - high programming voltage field reads zero
// - valid after flash init; internal boot immediate
// - external boot: bits 15,14 high until init
// - before init: f0d0h and 0040h, others normal
`timescale 1ns/10ps
`default_nettype none
`include "dir_defines.svh"

module dir_top #(
    parameter logic [10:0] MAKER_CODE       = 11'h2a5, // arbitrary value
    parameter logic [11:0] PART_ID          = 12'h5a6, // arbitrary value
    parameter logic [3:0]  SILICON_REVISION = 4'h1     // arbitrary value
) (
    input  wire logic              core_clk_in,
    input  wire logic              rst_in,
    input  wire dir_pkg::dir_req_t bus_req_in,
    input  wire logic              ext_boot_select_in,
    input  wire logic              flash_init_done_in,
    output logic [15:0]            rd_data_out,
    output logic                   ack_out,
    output logic                   unmapped_out,
    output logic                   wr_ignored_out,
    output logic                   id_ready_out,
    output logic                   boot_internal_out
);

    // address decode, shared by the read and write paths
    function automatic dir_pkg::dir_hit_t dir_decode(
        input logic        short_sel,
        input logic [15:0] addr
    );
        dir_pkg::dir_hit_t r;
        r.hit = 1'b1;
        r.idx = dir_pkg::DIR_IDX_PROGV;
        if (short_sel) begin
            case (addr[7:0])
                `DIR_PROGV_SHORT:   r.idx = dir_pkg::DIR_IDX_PROGV;
                `DIR_MEMDESC_SHORT: r.idx = dir_pkg::DIR_IDX_MEMDESC;
                `DIR_PART_SHORT:    r.idx = dir_pkg::DIR_IDX_PART;
                `DIR_MAKER_SHORT:   r.idx = dir_pkg::DIR_IDX_MAKER;
                default:            r.hit = 1'b0;
            endcase
            // short addresses are 8 bits; anything above must be zero
            if (addr[15:8] != 8'h00) begin
                r.hit = 1'b0;
            end
        end else begin
            case (addr)
                `DIR_PROGV_ADDR:   r.idx = dir_pkg::DIR_IDX_PROGV;
                `DIR_MEMDESC_ADDR: r.idx = dir_pkg::DIR_IDX_MEMDESC;
                `DIR_PART_ADDR:    r.idx = dir_pkg::DIR_IDX_PART;
                `DIR_MAKER_ADDR:   r.idx = dir_pkg::DIR_IDX_MAKER;
                default:           r.hit = 1'b0;
            endcase
        end
        return r;
    endfunction : dir_decode

    // strap and init state
    logic               boot_sync1_q;
    logic               boot_sync2_q;
    logic               boot_internal_q;
    dir_pkg::dir_state_t state_q;
    dir_pkg::dir_state_t state_d;
    logic               ready_now;
    logic               id_ready_q;

    // access path
    dir_pkg::dir_hit_t  rd_hit;
    dir_pkg::dir_hit_t  wr_hit;
    logic               rd_take;
    logic               rd_load;
    logic               rd_zero;
    logic               ack_q;
    logic               unmapped_q;
    logic               wr_ignored_q;
    logic [15:0]        rom_data;

    // boot select pin synchroniser; the first stage feeds only the second
    // no reset here: the pin must be sampled while reset is still held
    always_ff @(posedge core_clk_in) begin
        boot_sync1_q <= ext_boot_select_in;
        boot_sync2_q <= boot_sync1_q;
    end

    // strap capture: follows the pin while reset is held, frozen at release
    // the pin must be stable for three cycles before reset ends
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            boot_internal_q <= boot_sync2_q;
        end
    end

    // init tracking
    always_comb begin
        state_d = state_q;
        case (state_q)
            dir_pkg::DIR_ST_RESET: begin
                if (boot_internal_q) begin
                    state_d = dir_pkg::DIR_ST_READY;
                end else if (flash_init_done_in) begin
                    state_d = dir_pkg::DIR_ST_READY;
                end else begin
                    state_d = dir_pkg::DIR_ST_WAIT_FLASH;
                end
            end
            dir_pkg::DIR_ST_WAIT_FLASH: begin
                if (flash_init_done_in) begin
                    state_d = dir_pkg::DIR_ST_READY;
                end
            end
            dir_pkg::DIR_ST_READY: begin
                state_d = dir_pkg::DIR_ST_READY;
            end
            // an illegal code restarts the wait for flash init
            default: begin
                state_d = dir_pkg::DIR_ST_RESET;
            end
        endcase
    end

    // init state register
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_q <= dir_pkg::DIR_ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // internal boot counts as ready from the first cycle after release,
    // so a read issued right away already sees the final words
    // an external boot waits for the flash controller's done level
    assign ready_now = (state_q == dir_pkg::DIR_ST_READY) ||
                       ((state_q == dir_pkg::DIR_ST_RESET) &&
                        (boot_internal_q || flash_init_done_in));

    // sticky ready flag; only a reset clears it
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            id_ready_q <= 1'b0;
        end else begin
            id_ready_q <= ready_now;
        end
    end

    // request decode; a read wins over a write in the same cycle
    // the write decode is kept apart so the two paths stay independent
    assign rd_hit  = dir_decode(bus_req_in.short_sel, bus_req_in.addr);
    assign wr_hit  = dir_decode(bus_req_in.short_sel, bus_req_in.addr);
    assign rd_take = bus_req_in.rd;
    assign rd_load = rd_take && rd_hit.hit;
    assign rd_zero = rd_take && !rd_hit.hit;

    // one acknowledge per access, read or write, one cycle later
    // a request seen during reset is dropped without an answer
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req_in.rd || bus_req_in.wr;
        end
    end

    // unmapped reads answer with zero data; every unmapped access raises a flag
    // when both strobes are up the read decode decides
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            unmapped_q <= 1'b0;
        end else if (bus_req_in.rd) begin
            unmapped_q <= !rd_hit.hit;
        end else if (bus_req_in.wr) begin
            unmapped_q <= !wr_hit.hit;
        end else begin
            unmapped_q <= 1'b0;
        end
    end

    // writes to a mapped word are dropped; the flag only tells software
    // that nothing was stored, the register contents never move
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wr_ignored_q <= 1'b0;
        end else begin
            wr_ignored_q <= bus_req_in.wr && !bus_req_in.rd && wr_hit.hit;
        end
    end

    // word store; write data is never routed into it
    // identity values are build-time constants; no bus path reaches them
    dir_rom u_rom (
        .core_clk_in         (core_clk_in),
        .rst_in              (rst_in),
        .load_in             (rd_load),
        .zero_in             (rd_zero),
        .idx_in              (rd_hit.idx),
        .ready_in            (ready_now),
        .maker_code_in       (MAKER_CODE),
        .part_id_in          (PART_ID),
        .silicon_revision_in (SILICON_REVISION),
        .rd_data_out         (rom_data)
    );

    // every output is a flip-flop; these are plain wires
    assign rd_data_out       = rom_data;
    assign ack_out           = ack_q;
    assign unmapped_out      = unmapped_q;
    assign wr_ignored_out    = wr_ignored_q;
    assign id_ready_out      = id_ready_q;
    assign boot_internal_out = boot_internal_q;

endmodule : dir_top
`default_nettype wire

/* File: tb/dir_top_props.sv */
// port checker for the identification bank
`timescale 1ns/10ps
`default_nettype none
module dir_top_props #(
    parameter logic [10:0] MAKER_CODE       = 11'h2a5,
    parameter logic [11:0] PART_ID          = 12'h5a6,
    parameter logic [3:0]  SILICON_REVISION = 4'h1
) (
    input wire logic              core_clk_in,
    input wire logic              rst_in,
    input wire dir_pkg::dir_req_t bus_req_in,
    input wire logic              ext_boot_select_in,
    input wire logic              flash_init_done_in,
    input wire logic [15:0]       rd_data_out,
    input wire logic              ack_out,
    input wire logic              unmapped_out,
    input wire logic              wr_ignored_out,
    input wire logic              id_ready_out,
    input wire logic              boot_internal_out
);
    logic       hit;
    logic [1:0] idx;
    logic       acc;
    // own decode of the four words, full or short form
    assign hit = bus_req_in.short_sel ? (bus_req_in.addr[15:2] == 14'h000f)
               : (bus_req_in.addr[15:3] == 13'h1e0f && !bus_req_in.addr[0]);
    assign idx = bus_req_in.short_sel ? bus_req_in.addr[1:0] : bus_req_in.addr[2:1];
    assign acc = bus_req_in.rd || bus_req_in.wr;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // mapped read of one word
    sequence s_rd(logic [1:0] i);
        bus_req_in.rd && hit && idx == i;
    endsequence
    property p_ack; acc |=> ack_out; endproperty
    property p_idle; !acc |=> !ack_out && !unmapped_out && !wr_ignored_out; endproperty
    property p_unm; acc && !hit |=> unmapped_out && !wr_ignored_out; endproperty
    property p_wr; bus_req_in.wr && !bus_req_in.rd && hit |=> wr_ignored_out; endproperty
    property p_hold; !bus_req_in.rd |=> $stable(rd_data_out); endproperty
    property p_maker; s_rd(2'd3) |=> rd_data_out == {MAKER_CODE, 5'h03}; endproperty
    property p_part; s_rd(2'd2) |=> rd_data_out == {PART_ID, SILICON_REVISION}; endproperty
    property p_progv; s_rd(2'd0) |=> rd_data_out == 16'h0040; endproperty
    property p_ready; s_rd(2'd1) ##0 id_ready_out |=> rd_data_out == 16'h30d0; endproperty
    property p_busy;
        s_rd(2'd1) ##0 !(id_ready_out || flash_init_done_in || boot_internal_out)
        |=> rd_data_out == 16'hf0d0;
    endproperty
    property p_init; boot_internal_out || flash_init_done_in |-> ##[0:2] id_ready_out; endproperty
    a_ack:
        assert property (p_ack) else $error("no answer to access");
    a_idle:
        assert property (p_idle) else $error("answer without access");
    a_unm:
        assert property (p_unm) else $error("unmapped access not flagged");
    a_wr:
        assert property (p_wr) else $error("write not dropped");
    a_hold:
        assert property (p_hold) else $error("read data moved without read");
    a_maker:
        assert property (p_maker) else $error("maker word wrong");
    a_part:
        assert property (p_part) else $error("part word wrong");
    a_progv:
        assert property (p_progv) else $error("supply word wrong");
    a_ready:
        assert property (p_ready) else $error("memory word wrong");
    a_busy:
        assert property (p_busy) else $error("busy memory word wrong");
    a_init:
        assert property (p_init) else $error("ready late");
endmodule : dir_top_props
`default_nettype wire

/* File: tb/test_dir_top.sv */
// self-checking bench for the identification bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module test_dir_top;
    localparam logic [10:0] MK = 11'h155; // arbitrary value
    localparam logic [11:0] PI = 12'h3c9; // arbitrary value
    localparam logic [3:0]  RV = 4'h7;    // arbitrary value
    localparam logic [15:0] FULL [4] = '{16'hf078, 16'hf07a, 16'hf07c, 16'hf07e};
    logic              core_clk_in = 1'b0;
    logic              rst_in = 1'b1;
    dir_pkg::dir_req_t req = '0;
    logic              ext_boot = 1'b0;
    logic              done = 1'b0;
    logic [15:0]       rd_data;
    logic              ack, unm, wri, rdy, bint;
    logic [15:0]       expv [4];
    int                num_errors = 0;
    int                check_count = 0;
    int                n;

    dir_top #(.MAKER_CODE(MK), .PART_ID(PI), .SILICON_REVISION(RV)) i_dut (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .bus_req_in(req),
        .ext_boot_select_in(ext_boot), .flash_init_done_in(done), .rd_data_out(rd_data),
        .ack_out(ack), .unmapped_out(unm), .wr_ignored_out(wri), .id_ready_out(rdy),
        .boot_internal_out(bint));

    always #4 core_clk_in = ~core_clk_in;

    // one access: strobe held a cycle, answer looked at one cycle later
    task automatic acc(input logic r, input logic w, input logic s, input logic [15:0] a);
        @(negedge core_clk_in);
        req = '{rd: r, wr: w, short_sel: s, addr: a, wdata: 16'ha5a5};
        @(negedge core_clk_in);
        req.rd = 1'b0;
        req.wr = 1'b0;
        `CHK(ack, 1'b1)
    endtask : acc

    task automatic rdchk(input logic s, input logic [15:0] a, input logic [15:0] e);
        acc(1'b1, 1'b0, s, a);
        `CHK(rd_data, e)
    endtask : rdchk

    // three edges so the strap passes both sync stages; a read may be
    // presented with the release, taken at the first edge after it
    task automatic do_reset(input logic eb, input logic rd_now);
        @(negedge core_clk_in);
        rst_in = 1'b1;
        ext_boot = eb;
        done = 1'b0;
        repeat (3) @(negedge core_clk_in);
        rst_in = 1'b0;
        req = '{rd: rd_now, wr: 1'b0, short_sel: 1'b1, addr: 16'h003d, wdata: 16'ha5a5};
    endtask : do_reset

    task automatic finish_test;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    initial begin
        #100000;
        $display("MISMATCH %0t run timeout", $time);
        num_errors++;
        finish_test();
    end

    initial begin
        // external boot, flash still busy
        do_reset(1'b0, 1'b0);
        `CHK({bint, rdy, ack, rd_data}, {3'b000, 16'h0000})
        expv = '{16'h0040, 16'hf0d0, {PI, RV}, {MK, 5'h03}};
        for (int i = 0; i < 4; i++) begin
            rdchk(1'b0, FULL[i], expv[i]);
            rdchk(1'b1, 16'h003c + i[15:0], expv[i]);
        end
        // writes dropped on every word
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 1'b1, i[0], i[0] ? 16'h003c + i[15:0] : FULL[i]);
            `CHK({wri, unm}, 2'b10)
            rdchk(1'b0, FULL[i], expv[i]);
        end
        acc(1'b1, 1'b0, 1'b0, 16'hf080);
        `CHK({unm, rd_data}, {1'b1, 16'h0000})
        acc(1'b0, 1'b1, 1'b1, 16'h013d);
        `CHK({unm, wri}, 2'b10)
        acc(1'b1, 1'b0, 1'b0, 16'hf07b);
        `CHK(unm, 1'b1)
        // read and write together act as a read
        acc(1'b1, 1'b1, 1'b1, 16'h003f);
        `CHK({wri, rd_data}, {1'b0, MK, 5'h03})
        repeat (3) rdchk(1'b1, 16'h003d, 16'hf0d0);
        // software poll of the busy bits, bounded
        done = 1'b1;
        n = 0;
        do begin
            acc(1'b1, 1'b0, 1'b1, 16'h003d);
            n++;
            if (n > 20) begin
                $display("MISMATCH %0t poll timeout", $time);
                num_errors++;
                finish_test();
            end
        end while (rd_data[15:14] !== 2'b00);
        `CHK(rd_data, 16'h30d0)
        done = 1'b0;
        rdchk(1'b0, 16'hf07a, 16'h30d0);
        rdchk(1'b1, 16'h003c, 16'h0040);
        // internal boot: a read taken at the first edge after release is final
        do_reset(1'b1, 1'b1);
        `CHK({bint, rdy, rd_data}, {2'b10, 16'h0000})
        @(negedge core_clk_in);
        req.rd = 1'b0;
        `CHK({ack, rd_data}, {1'b1, 16'h30d0})
        rdchk(1'b0, 16'hf07a, 16'h30d0);
        `CHK({bint, rdy}, 2'b11)
        finish_test();
    end
endmodule : test_dir_top

bind dir_top dir_top_props #(
    .MAKER_CODE(MAKER_CODE), .PART_ID(PART_ID), .SILICON_REVISION(SILICON_REVISION)
) i_props (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .bus_req_in(bus_req_in),
    .ext_boot_select_in(ext_boot_select_in), .flash_init_done_in(flash_init_done_in),
    .rd_data_out(rd_data_out), .ack_out(ack_out), .unmapped_out(unmapped_out),
    .wr_ignored_out(wr_ignored_out), .id_ready_out(id_ready_out),
    .boot_internal_out(boot_internal_out));
`default_nettype wire
